//--- rtl/prrs_map.svh
// Register indices, field positions and reset values of the ratio and reference selector
`ifndef PRRS_MAP_SVH
`define PRRS_MAP_SVH

`define PRRS_IDX_CAL_CTRL 8'h0E
`define PRRS_IDX_BAND 8'h10
`define PRRS_IDX_XCAP 8'h1B
`define PRRS_IDX_REFCTL 8'h1D
`define PRRS_IDX_VCO_TGT 8'h40
`define PRRS_IDX_OUT_TGT 8'h41
`define PRRS_IDX_STATUS 8'h42

`define PRRS_CAL_FORCE_BIT 7
`define PRRS_CAL_SPI_EN_BIT 2
`define PRRS_BAND_SPI_EN_BIT 0
`define PRRS_XCAP_SEL_BIT 7
`define PRRS_USE_CRYSTAL_PINS_BIT 0
`define PRRS_DBL_EN_BIT 2

`define PRRS_CAL_CTRL_RST 8'h00
`define PRRS_BAND_RST 7'h00
`define PRRS_XCAP_RST 8'hBF
`define PRRS_REFCTL_RST 8'h00
`define PRRS_CAP_PIN_CODE 6'h08
`define PRRS_DBL_MAX_CODE 3'h3

`endif

//--- rtl/prrs_pkg.sv
// Types shared by the ratio and reference selector files
package prrs_pkg;

    typedef struct packed {
        logic [2:0] ref_code;
        logic [5:0] out_code;
    } prrs_strap_t;

    typedef struct packed {
        logic [21:0] vco_khz;
        logic [19:0] out_khz;
    } prrs_preset_t;

    typedef enum logic [3:0] {
        PRRS_CAL_IDLE = 4'b0001,
        PRRS_CAL_WAIT_REF = 4'b0010,
        PRRS_CAL_RUN = 4'b0100,
        PRRS_CAL_DONE = 4'b1000
    } prrs_cal_state_t;

endpackage

//--- rtl/prrs_preset_rom.sv
// Preset table of oscillator and output targets indexed by the output strap code
module prrs_preset_rom
    import prrs_pkg::*;
(
    input wire logic clk_i,
    input wire logic [5:0] addr_i,
    output prrs_preset_t data_o
);

    // Nominal values in kHz, fractional entries truncated
    always_ff @(posedge clk_i) begin
        case (addr_i)
            6'h00: data_o <= {22'd3732480, 20'd51840};
            6'h01: data_o <= {22'd3888000, 20'd54000};
            6'h02: data_o <= {22'd3840000, 20'd60000};
            6'h03: data_o <= {22'd3932160, 20'd61440};
            6'h04: data_o <= {22'd3750000, 20'd62500};
            6'h05: data_o <= {22'd3733296, 20'd66666};
            6'h06: data_o <= {22'd3560439, 20'd74175};
            6'h07: data_o <= {22'd3564000, 20'd74250};
            6'h08: data_o <= {22'd3732480, 20'd77760};
            6'h09: data_o <= {22'd3932160, 20'd98304};
            6'h0A: data_o <= {22'd4000000, 20'd100000};
            6'h0B: data_o <= {22'd3825000, 20'd106250};
            6'h0C: data_o <= {22'd3840000, 20'd120000};
            6'h0D: data_o <= {22'd4000000, 20'd125000};
            6'h0E: data_o <= {22'd3724000, 20'd133000};
            6'h0F: data_o <= {22'd3732480, 20'd155520};
            6'h10: data_o <= {22'd3750000, 20'd156250};
            6'h11: data_o <= {22'd3825000, 20'd159375};
            6'h12: data_o <= {22'd3867188, 20'd161132};
            6'h13: data_o <= {22'd3944531, 20'd164355};
            6'h14: data_o <= {22'd3999086, 20'd166628};
            6'h15: data_o <= {22'd4015959, 20'd167331};
            6'h16: data_o <= {22'd4023878, 20'd167661};
            6'h17: data_o <= {22'd3554742, 20'd177737};
            6'h18: data_o <= {22'd3932160, 20'd245760};
            6'h19: data_o <= {22'd4000000, 20'd250000};
            6'h1A: data_o <= {22'd3732480, 20'd311040};
            6'h1B: data_o <= {22'd3840000, 20'd320000};
            6'h1C: data_o <= {22'd4000000, 20'd400000};
            6'h1D: data_o <= {22'd3471400, 20'd433925};
            6'h1E: data_o <= {22'd3718750, 20'd531250};
            6'h1F: data_o <= {22'd3763200, 20'd537600};
            6'h20: data_o <= {22'd3984375, 20'd569196};
            6'h21: data_o <= {22'd3732480, 20'd622080};
            6'h22: data_o <= {22'd3748229, 20'd624704};
            6'h23: data_o <= {22'd3750000, 20'd625000};
            6'h24: data_o <= {22'd3763978, 20'd627329};
            6'h25: data_o <= {22'd3779927, 20'd629987};
            6'h26: data_o <= {22'd3840000, 20'd640000};
            6'h27: data_o <= {22'd3849120, 20'd641520};
            6'h28: data_o <= {22'd3867188, 20'd644531};
            6'h29: data_o <= {22'd3944531, 20'd657421};
            6'h2A: data_o <= {22'd3961105, 20'd660184};
            6'h2B: data_o <= {22'd3999086, 20'd666514};
            6'h2C: data_o <= {22'd4014769, 20'd669128};
            6'h2D: data_o <= {22'd4015959, 20'd669326};
            6'h2E: data_o <= {22'd4017857, 20'd669642};
            6'h2F: data_o <= {22'd4025032, 20'd670838};
            6'h30: data_o <= {22'd4032976, 20'd672162};
            6'h31: data_o <= {22'd3452846, 20'd690569};
            6'h32: data_o <= {22'd3467415, 20'd693482};
            6'h33: data_o <= {22'd3468750, 20'd693750};
            6'h34: data_o <= {22'd3481996, 20'd696399};
            6'h35: data_o <= {22'd3521903, 20'd704380};
            6'h36: data_o <= {22'd3536763, 20'd707352};
            6'h37: data_o <= {22'd3582686, 20'd716537};
            6'h38: data_o <= {22'd3593750, 20'd718750};
            6'h39: data_o <= {22'd3598672, 20'd719734};
            6'h3A: data_o <= {22'd3740355, 20'd748070};
            6'h3B: data_o <= {22'd3750000, 20'd750000};
            6'h3C: data_o <= {22'd3888000, 20'd777600};
            6'h3D: data_o <= {22'd3897843, 20'd779568};
            6'h3E: data_o <= {22'd3906250, 20'd781250};
            default: data_o <= {22'd4028320, 20'd805664};
        endcase
    end

endmodule

//--- rtl/prrs_cal_seq.sv
// Oscillator calibration sequencer: automatic start after reset and forced restart
module prrs_cal_seq
    import prrs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic presets_ready_i,
    input wire logic ref_valid_i,
    input wire logic force_i,
    input wire logic cal_done_i,
    output logic cal_start_o,
    output logic cal_busy_o,
    output logic cal_ok_o
);

    prrs_cal_state_t state_r;
    prrs_cal_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PRRS_CAL_IDLE: begin
                if (presets_ready_i) begin
                    state_nxt = PRRS_CAL_WAIT_REF;
                end
            end
            PRRS_CAL_WAIT_REF: begin
                // Hold off until a usable reference shows up
                if (ref_valid_i) begin
                    state_nxt = PRRS_CAL_RUN;
                end
            end
            PRRS_CAL_RUN: begin
                // Force requests during a run are dropped
                if (cal_done_i) begin
                    state_nxt = PRRS_CAL_DONE;
                end
            end
            PRRS_CAL_DONE: begin
                if (force_i) begin
                    state_nxt = PRRS_CAL_WAIT_REF;
                end
            end
            default: state_nxt = PRRS_CAL_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= PRRS_CAL_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_start_o <= 1'b0;
        end else begin
            cal_start_o <= (state_r == PRRS_CAL_WAIT_REF) && ref_valid_i;
        end
    end

    assign cal_busy_o = (state_r != PRRS_CAL_DONE);
    assign cal_ok_o = (state_r == PRRS_CAL_DONE);

endmodule

//--- rtl/prrs_top.sv
// Preset ratio decoder, reference selector and calibration control with Wishbone registers
//
// Contract
// R1 - Grounded strap reads zero, open strap reads one
// R2 - Software-written targets override the strapped presets
// R3 - Three reference straps pick eight nominal frequencies
// R4 - Low reference codes enable the input doubler
// R5 - Doubler register bit also enables doubling
// R6 - Six output straps index the 64-entry preset table
// R7 - Presets applied unchanged whatever reference is supplied
// R8 - Calibration runs automatically after power-up and reset
// R9 - Host enables calibration control before forcing calibration
// R10 - Load capacitance defaults to 2 pF after reset
// R11 - Six-bit field sets capacitance in quarter picofarads
// R12 - Clearing select bit hands capacitance to field
// R13 - Detected external clock wins; crystal oscillator off
// R14 - Use-crystal bit ignores detector, keeps crystal on
// R15 - Active-high reset returns all logic to defaults
// R16 - Both present at power-up: external path chosen
// R17 - Calibration waits for a valid reference
// R18 - Capacitance equals field code times 0.25 pF
// R19 - Straps sampled at reset release before calibration
`include "prrs_map.svh"

module prrs_top
    import prrs_pkg::*;
#(
    parameter int AW = 10
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] strap_ref_i,
    input wire logic [5:0] strap_out_i,
    input wire logic ref_det_i,
    input wire logic crystal_pins_ok_i,
    input wire logic cal_done_i,
    output logic [15:0] ref_khz_o,
    output logic doubler_en_o,
    output logic ref_ext_sel_o,
    output logic crystal_pins_osc_en_o,
    output logic [5:0] cap_code_o,
    output logic [21:0] vco_tgt_khz_o,
    output logic [19:0] out_tgt_khz_o,
    output logic cal_start_o,
    output logic band_ovr_o,
    output logic [6:0] band_o
);

    function automatic logic [15:0] nominal_ref_khz(input logic [2:0] code);
        case (code)
            3'h0: nominal_ref_khz = 16'h2710;
            3'h1: nominal_ref_khz = 16'h2EE0;
            3'h2: nominal_ref_khz = 16'h3200;
            3'h3: nominal_ref_khz = 16'h3E80;
            3'h4: nominal_ref_khz = 16'h4B00;
            3'h5: nominal_ref_khz = 16'h4BF0;
            3'h6: nominal_ref_khz = 16'h4E20;
            default: nominal_ref_khz = 16'h6590;
        endcase
    endfunction

    function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        byte_merge = res;
    endfunction

    prrs_strap_t strap_r;
    prrs_preset_t rom_q;
    logic preset_vld_r;
    logic ack_r;
    logic [31:0] dat_r;
    logic [7:0] cal_ctrl_r;
    logic [6:0] band_r;
    logic [7:0] xcap_r;
    logic [7:0] refctl_r;
    logic [31:0] vco_ovr_r;
    logic [31:0] out_ovr_r;
    logic ovr_vco_r;
    logic ovr_out_r;
    logic doubler_r;
    logic ref_ext_r;
    logic crystal_pins_en_r;
    logic [5:0] cap_r;
    logic [21:0] vco_tgt_r;
    logic [19:0] out_tgt_r;
    logic [7:0] idx;
    logic req;
    logic wr_acc;
    logic force_cal;
    logic ref_valid;
    logic use_ext;
    logic cal_busy;
    logic cal_ok;
    logic [31:0] rd_mux;

    // Straps follow the pins while reset is held; the last value stays
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_r <= '{ref_code: strap_ref_i, out_code: strap_out_i}; // see R1, R19
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preset_vld_r <= 1'b0;
        end else begin
            preset_vld_r <= 1'b1;
        end
    end

    prrs_preset_rom u_rom (
        .clk_i(clk_i),
        .addr_i(strap_r.out_code), // see R6
        .data_o(rom_q)
    );

    // Bus slave: one wait state, ack drops after one cycle
    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i;
    assign wr_acc = req && wb_we_i && ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (idx)
            `PRRS_IDX_CAL_CTRL: rd_mux = {24'h00_0000, cal_busy, cal_ctrl_r[6:0]};
            `PRRS_IDX_BAND: rd_mux = {24'h00_0000, band_r, 1'b0};
            `PRRS_IDX_XCAP: rd_mux = {24'h00_0000, xcap_r[7], 1'b0, xcap_r[5:0]};
            `PRRS_IDX_REFCTL: rd_mux = {24'h00_0000, 5'h00, refctl_r[2], 1'b0, refctl_r[0]};
            `PRRS_IDX_VCO_TGT: rd_mux = {10'h000, vco_tgt_r};
            `PRRS_IDX_OUT_TGT: rd_mux = {12'h000, out_tgt_r};
            `PRRS_IDX_STATUS: rd_mux = {15'h0000, strap_r, 2'h0, cal_ok, cal_busy,
                                        ref_ext_r, doubler_r, ovr_out_r, ovr_vco_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !ack_r) begin
            dat_r <= rd_mux;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Byte-wide registers answer on lane 0 only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_ctrl_r <= `PRRS_CAL_CTRL_RST; // see R15
            band_r <= `PRRS_BAND_RST;
            xcap_r <= `PRRS_XCAP_RST; // see R10
            refctl_r <= `PRRS_REFCTL_RST;
        end else if (wr_acc && wb_sel_i[0]) begin
            case (idx)
                `PRRS_IDX_CAL_CTRL: cal_ctrl_r <= {1'b0, wb_dat_i[6:0]};
                `PRRS_IDX_BAND: band_r <= wb_dat_i[7:1];
                `PRRS_IDX_XCAP: xcap_r <= wb_dat_i[7:0]; // see R11
                `PRRS_IDX_REFCTL: refctl_r <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Calibrate only counts once control was already handed to software
    assign force_cal = wr_acc && wb_sel_i[0] && (idx == `PRRS_IDX_CAL_CTRL)
                       && wb_dat_i[`PRRS_CAL_FORCE_BIT]
                       && cal_ctrl_r[`PRRS_CAL_SPI_EN_BIT]; // see R9

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vco_ovr_r <= 32'h0000_0000;
            ovr_vco_r <= 1'b0;
        end else if (wr_acc && (idx == `PRRS_IDX_VCO_TGT) && (wb_sel_i != 4'h0)) begin
            vco_ovr_r <= byte_merge(vco_ovr_r, wb_dat_i, wb_sel_i);
            ovr_vco_r <= 1'b1; // see R2
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_ovr_r <= 32'h0000_0000;
            ovr_out_r <= 1'b0;
        end else if (wr_acc && (idx == `PRRS_IDX_OUT_TGT) && (wb_sel_i != 4'h0)) begin
            out_ovr_r <= byte_merge(out_ovr_r, wb_dat_i, wb_sel_i);
            ovr_out_r <= 1'b1; // see R2
        end
    end

    // Targets stay nominal whatever reference is supplied
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            vco_tgt_r <= 22'h00_0000;
            out_tgt_r <= 20'h0_0000;
        end else begin
            vco_tgt_r <= ovr_vco_r ? vco_ovr_r[21:0] : rom_q.vco_khz; // see R2, R6, R7
            out_tgt_r <= ovr_out_r ? out_ovr_r[19:0] : rom_q.out_khz; // see R2, R6, R7
        end
    end

    assign use_ext = ref_det_i && !refctl_r[`PRRS_USE_CRYSTAL_PINS_BIT]; // see R13, R14, R16
    assign ref_valid = use_ext || crystal_pins_ok_i; // see R17

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            doubler_r <= 1'b0;
            ref_ext_r <= 1'b0;
            crystal_pins_en_r <= 1'b1;
            cap_r <= `PRRS_CAP_PIN_CODE;
        end else begin
            doubler_r <= (strap_r.ref_code <= `PRRS_DBL_MAX_CODE)
                         || refctl_r[`PRRS_DBL_EN_BIT]; // see R4, R5
            ref_ext_r <= use_ext; // see R13, R16
            crystal_pins_en_r <= !use_ext; // see R13, R14
            // Code is quarter-pF steps, so 0x3F is 15.75 pF
            cap_r <= xcap_r[`PRRS_XCAP_SEL_BIT] ? `PRRS_CAP_PIN_CODE
                                                : xcap_r[5:0]; // see R10, R12, R18
        end
    end

    prrs_cal_seq u_cal (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .presets_ready_i(preset_vld_r), // see R19
        .ref_valid_i(ref_valid), // see R17
        .force_i(force_cal),
        .cal_done_i(cal_done_i),
        .cal_start_o(cal_start_o), // see R8
        .cal_busy_o(cal_busy),
        .cal_ok_o(cal_ok)
    );

    assign ref_khz_o = nominal_ref_khz(strap_r.ref_code); // see R3
    assign doubler_en_o = doubler_r;
    assign ref_ext_sel_o = ref_ext_r;
    assign crystal_pins_osc_en_o = crystal_pins_en_r;
    assign cap_code_o = cap_r;
    assign vco_tgt_khz_o = vco_tgt_r;
    assign out_tgt_khz_o = out_tgt_r;
    assign band_ovr_o = cal_ctrl_r[`PRRS_BAND_SPI_EN_BIT];
    assign band_o = band_r;

    property p_strap_capture;
        @(posedge clk_i) $fell(rst_i) |-> strap_r == $past({strap_ref_i, strap_out_i});
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("strap not latched"); // see R19

    property p_ref_freq;
        @(posedge clk_i) disable iff (rst_i)
        (strap_r.ref_code == 3'h5) |-> ref_khz_o == 16'h4BF0;
    endproperty
    a_ref_freq: assert property (p_ref_freq) else $error("nominal reference wrong"); // see R3

    property p_doubler;
        @(posedge clk_i) disable iff (rst_i)
        preset_vld_r |=> doubler_en_o == (($past(strap_r.ref_code) < 3'h4)
                                          || $past(refctl_r[2]));
    endproperty
    a_doubler: assert property (p_doubler) else $error("doubler state wrong"); // see R4, R5

    property p_preset_zero;
        @(posedge clk_i) disable iff (rst_i)
        (preset_vld_r && !ovr_vco_r && !ovr_out_r && strap_r.out_code == 6'h00)
        |=> vco_tgt_khz_o == 22'h38F400 && out_tgt_khz_o == 20'h0CA80;
    endproperty
    a_preset_zero: assert property (p_preset_zero) else $error("preset zero wrong"); // see R6

    property p_override;
        @(posedge clk_i) disable iff (rst_i)
        ovr_vco_r |=> vco_tgt_khz_o == $past(vco_ovr_r[21:0]);
    endproperty
    a_override: assert property (p_override) else $error("override not applied"); // see R2

    property p_cap;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> cap_code_o == ($past(xcap_r[7]) ? 6'h08 : $past(xcap_r[5:0]));
    endproperty
    a_cap: assert property (p_cap) else $error("capacitance code wrong"); // see R10, R12

    property p_src_sel;
        @(posedge clk_i) disable iff (rst_i)
        (ref_det_i && !refctl_r[0]) |=> ref_ext_sel_o && !crystal_pins_osc_en_o;
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("external not chosen"); // see R13, R16

    property p_use_crystal_pins;
        @(posedge clk_i) disable iff (rst_i)
        refctl_r[0] |=> crystal_pins_osc_en_o && !ref_ext_sel_o;
    endproperty
    a_use_crystal_pins: assert property (p_use_crystal_pins) else $error("crystal not forced"); // see R14

    property p_cal_needs_ref;
        @(posedge clk_i) disable iff (rst_i)
        cal_start_o |-> $past(ref_valid);
    endproperty
    a_cal_needs_ref: assert property (p_cal_needs_ref) else $error("start without ref"); // see R17

    property p_auto_cal;
        @(posedge clk_i) disable iff (rst_i)
        ($fell(rst_i) ##0 ref_valid [*3]) |-> ##[0:1] cal_start_o;
    endproperty
    a_auto_cal: assert property (p_auto_cal) else $error("no automatic calibration"); // see R8

    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");

    c_auto_cal: cover property (@(posedge clk_i) disable iff (rst_i) cal_start_o ##[1:50] cal_ok);
    c_force_cal: cover property (@(posedge clk_i) disable iff (rst_i) force_cal ##[1:20] cal_start_o);
    c_crystal_pins: cover property (@(posedge clk_i) disable iff (rst_i) ref_det_i && crystal_pins_osc_en_o);
    c_ovr: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ovr_vco_r));

endmodule

//--- tb/prrs_analog_model.sv
// Behavioural analog calibration engine answering start pulses
module prrs_analog_model (
    input wire logic clk_i,
    input wire logic cal_start_i,
    input wire logic slow_i,
    output logic cal_done_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial cal_done_o = 1'b0;
    // Slow mode keeps the engine busy long enough to test refused forces
    always @(posedge clk_i) begin
        cal_done_o <= 1'b0;
        if (cal_start_i === 1'b1) begin
            cnt <= slow_i ? 40 : 3;
        end else if (cnt == 1) begin
            cal_done_o <= 1'b1;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

//--- tb/prrs_top_tb.sv
// Self-checking bench of the ratio and reference selector
`include "prrs_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module prrs_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [9:0] wb_adr = 10'h000;
    logic [31:0] wb_dat = 32'h00000000, wb_dat_o, q, seed = 32'h00000062;
    logic wb_ack_o, doubler_en_o, ref_ext_sel_o, crystal_pins_osc_en_o, cal_start_o, band_ovr_o;
    logic [6:0] band_o;
    logic [2:0] strap_ref = 3'h0;
    logic [5:0] strap_out = 6'h00, cap_code_o;
    logic ref_det = 1'b1, crystal_pins_ok = 1'b1, cal_done, slow = 1'b0;
    logic [15:0] ref_khz_o;
    logic [21:0] vco_tgt_khz_o;
    logic [19:0] out_tgt_khz_o;
    int error_cnt = 0, checks_done = 0, starts = 0, s0;
    int ref_tab[8] = '{10000, 12000, 12800, 16000, 19200, 19440, 20000, 26000};
    int vco_tab[3] = '{3732480, 3888000, 3840000};
    int out_tab[3] = '{51840, 54000, 60000};
    int cap_q[$];
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (cal_start_o === 1'b1) starts <= starts + 1;
    prrs_top #(.AW(10)) prrs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .strap_ref_i(strap_ref), .strap_out_i(strap_out), .ref_det_i(ref_det),
        .crystal_pins_ok_i(crystal_pins_ok), .cal_done_i(cal_done), .ref_khz_o(ref_khz_o),
        .doubler_en_o(doubler_en_o), .ref_ext_sel_o(ref_ext_sel_o),
        .crystal_pins_osc_en_o(crystal_pins_osc_en_o), .cap_code_o(cap_code_o),
        .vco_tgt_khz_o(vco_tgt_khz_o), .out_tgt_khz_o(out_tgt_khz_o),
        .cal_start_o(cal_start_o), .band_ovr_o(band_ovr_o), .band_o(band_o));
    prrs_analog_model prrs_analog_model_inst (.clk_i(clk_i), .cal_start_i(cal_start_o),
        .slow_i(slow), .cal_done_o(cal_done));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic print_verdict;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
        int n;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'h0};
        wb_dat <= d;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 50) begin
            error_cnt++;
            print_verdict();
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
    // Board straps: open pin drives one, grounded pin zero
    task automatic do_reset(input logic [2:0] r, input logic [5:0] o);
        rst_i <= 1'b1;
        strap_ref <= r;
        strap_out <= o;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        `CHK(starts, 1)
        for (int i = 0; i < 8; i++) begin
            s0 = starts;
            do_reset(i[2:0], 6'(i % 3));
            `CHK(ref_khz_o, 16'(ref_tab[i]))
            `CHK(doubler_en_o, 1'(i < 4))
            `CHK(vco_tgt_khz_o, 22'(vco_tab[i % 3]))
            `CHK(out_tgt_khz_o, 20'(out_tab[i % 3]))
            `CHK(cap_code_o, 6'h08)
            `CHK({ref_ext_sel_o, crystal_pins_osc_en_o}, 2'h2)
            `CHK(starts - s0, 1)
        end
        wb(1'b1, `PRRS_IDX_REFCTL, 32'h00000004);
        `CHK(doubler_en_o, 1'b1)
        wb(1'b1, `PRRS_IDX_REFCTL, 32'h00000001);
        `CHK({ref_ext_sel_o, crystal_pins_osc_en_o}, 2'h1)
        wb(1'b0, `PRRS_IDX_XCAP, 32'h00000000);
        `CHK(q, 32'h000000BF)
        wb(1'b1, `PRRS_IDX_XCAP, 32'h0000003F);
        `CHK(cap_code_o, 6'h3F)
        repeat (4) begin
            seed = xs(seed);
            cap_q.push_back(int'(seed[5:0]));
            wb(1'b1, `PRRS_IDX_XCAP, {26'h0, seed[5:0]});
            `CHK(cap_code_o, 6'(cap_q.pop_front()))
        end
        seed = xs(seed);
        wb(1'b1, `PRRS_IDX_VCO_TGT, {10'h000, seed[21:0]});
        `CHK(vco_tgt_khz_o, seed[21:0])
        wb(1'b0, 8'h20, 32'h00000000);
        `CHK(q, 32'h00000000)
        wb(1'b1, `PRRS_IDX_OUT_TGT, {12'h000, seed[31:12]});
        `CHK(out_tgt_khz_o, seed[31:12])
        wb(1'b0, `PRRS_IDX_OUT_TGT, 32'h00000000);
        `CHK(q, {12'h000, seed[31:12]})
        wb(1'b1, `PRRS_IDX_BAND, {24'h000000, seed[7:0]});
        wb(1'b1, `PRRS_IDX_CAL_CTRL, 32'h00000001);
        `CHK({band_ovr_o, band_o}, {1'b1, seed[7:1]})
        wb(1'b0, `PRRS_IDX_BAND, 32'h00000000);
        `CHK(q, {24'h000000, seed[7:1], 1'b0})
        slow <= 1'b1;
        s0 = starts;
        wb(1'b1, `PRRS_IDX_CAL_CTRL, 32'h00000004);
        wb(1'b1, `PRRS_IDX_CAL_CTRL, 32'h00000084);
        wb(1'b1, `PRRS_IDX_CAL_CTRL, 32'h00000084);
        `CHK(starts - s0, 1)
        repeat (50) @(posedge clk_i);
        slow <= 1'b0;
        ref_det <= 1'b0;
        crystal_pins_ok <= 1'b0;
        s0 = starts;
        do_reset(3'h0, 6'h00);
        repeat (10) @(posedge clk_i);
        `CHK(starts - s0, 0)
        `CHK(cap_code_o, 6'h08)
        crystal_pins_ok <= 1'b1;
        repeat (8) @(posedge clk_i);
        `CHK(starts - s0, 1)
        `CHK({ref_ext_sel_o, crystal_pins_osc_en_o}, 2'h1)
        wb(1'b0, `PRRS_IDX_STATUS, 32'h00000000);
        `CHK(q, 32'h00000024)
        print_verdict();
    end
endmodule
